//--- core/adcseq_pkg.sv
package adcseq_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] SELECT_OFFSET = 8'h04;
    localparam logic [7:0] ACTIVE_OFFSET = 8'h08;
    localparam logic [7:0] RESULT_OFFSET = 8'h0c;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_START_BIT  = 1;
    localparam int CTRL_AUTO_BIT   = 2;
    localparam int CTRL_FREE_BIT   = 3;
    localparam int CTRL_DONE_BIT   = 4;
    localparam int CTRL_PS_LSB     = 5;
    localparam int CTRL_PS_MSB     = 7;

    // Selection and active register fields
    localparam int SEL_CHAN_LSB  = 0;
    localparam int SEL_CHAN_MSB  = 5;
    localparam int SEL_REF_LSB   = 6;
    localparam int SEL_REF_MSB   = 7;
    localparam int ACTIVE_BUSY_BIT = 8;

    localparam int CHAN_W   = 6;
    localparam int REF_W    = 2;
    localparam int RESULT_W = 10;
    localparam int PS_W     = 3;
    localparam int PCNT_W   = 7;
    localparam int HALF_W   = 6;

    localparam logic [CHAN_W-1:0]   CHAN_RESET   = 6'h00;
    localparam logic [REF_W-1:0]    REF_RESET    = 2'h0;
    localparam logic [PS_W-1:0]     PS_RESET     = 3'h0;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

    // Sample instant and length, in converter half cycles
    localparam logic [HALF_W-1:0] FIRST_SAMPLE_HALF  = 6'h1b;
    localparam logic [HALF_W-1:0] FIRST_END_HALF     = 6'h32;
    localparam logic [HALF_W-1:0] NORMAL_SAMPLE_HALF = 6'h03;
    localparam logic [HALF_W-1:0] NORMAL_END_HALF    = 6'h1a;
    localparam logic [HALF_W-1:0] AUTO_SAMPLE_HALF   = 6'h04;
    localparam logic [HALF_W-1:0] AUTO_END_HALF      = 6'h1b;
    localparam logic [HALF_W-1:0] FREE_SAMPLE_HALF   = 6'h05;
    localparam logic [HALF_W-1:0] FREE_END_HALF      = 6'h1c;
    // One converter cycle before the end
    localparam logic [HALF_W-1:0] LAST_CYCLE_HALVES  = 6'h02;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef enum logic [1:0] {
        ADCSEQ_SLEEP_ACTIVE,
        ADCSEQ_SLEEP_IDLE,
        ADCSEQ_SLEEP_NOISE,
        ADCSEQ_SLEEP_OTHER
    } adcseq_sleep_type;

    typedef enum logic [1:0] {
        ADCSEQ_KIND_FIRST,
        ADCSEQ_KIND_NORMAL,
        ADCSEQ_KIND_AUTO,
        ADCSEQ_KIND_FREE
    } adcseq_kind_type;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } adcseq_ahb_req_type;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } adcseq_ahb_rsp_type;

    typedef struct packed {
        logic [REF_W-1:0]  ref_sel;
        logic [CHAN_W-1:0] chan_sel;
    } adcseq_select_type;

endpackage : adcseq_pkg

//--- core/adcseq_sequencer.sv
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
// Behaviour
// - Auto trigger resets the converter clock prescaler for fixed start delay.
// - Auto-triggered sample-and-hold two converter cycles after trigger rising edge.
// - Trigger passes three CPU cycles of synchronisation before starting.
// - Free running restarts at completion; start bit stays set.
// - Length and sample instant follow first, normal, auto or free case.
// - Selection buffer copies continuously into active selection until start.
// - Active selection frozen while conversion runs.
// - Copying resumes in the last converter cycle before done.
// - Written start begins conversion at next converter clock rising edge.
// - Free-running change after completion applies one conversion later.
// - Idle or noise sleep entry starts a conversion once CPU halted.
// - Sleep-started conversion still raises completion request after early wake.
// - Other sleep states never disable the converter automatically.
// - Completion stores result, sets done flag, clears start in single mode.
// - Prescaler runs while enabled, held in reset while disabled.
// - Trigger edges during a conversion are ignored.
module adcseq_sequencer (
    // Clock and reset
    input  wire logic                           i_mclk,
    input  wire logic                           i_rst,
    // AHB-Lite register port
    input  wire adcseq_pkg::adcseq_ahb_req_type i_ahb,
    output adcseq_pkg::adcseq_ahb_rsp_type      o_ahb,
    // Core sleep state
    input  wire adcseq_pkg::adcseq_sleep_type   i_sleep_mode,
    input  wire logic                           i_cpu_halted,
    // Trigger source pin
    input  wire logic                           i_trigger,
    // Analog sampling path
    input  wire logic [adcseq_pkg::RESULT_W-1:0] i_sar_result,
    output adcseq_pkg::adcseq_select_type       o_active_select,
    output logic                                o_converter_clock,
    output logic                                o_sample_hold,
    output logic                                o_converting,
    output logic                                o_conversion_done,
    output logic                                o_conversion_done_flag
);

    typedef enum logic [1:0] {
        ADCSEQ_IDLE,
        ADCSEQ_WAIT_EDGE,
        ADCSEQ_CONVERT
    } adcseq_state_type;

    function automatic logic [adcseq_pkg::PCNT_W-1:0] half_length(
        input logic [adcseq_pkg::PS_W-1:0] ps);
        logic [adcseq_pkg::PCNT_W-1:0] len;
        len = 7'h01;
        if (ps != 3'h0) begin
            len = 7'h01 << (ps - 3'h1);
        end
        return len;
    endfunction : half_length

    function automatic logic [adcseq_pkg::HALF_W-1:0] end_half(
        input adcseq_pkg::adcseq_kind_type kind);
        logic [adcseq_pkg::HALF_W-1:0] h;
        h = adcseq_pkg::NORMAL_END_HALF;
        unique case (kind)
            adcseq_pkg::ADCSEQ_KIND_FIRST:  h = adcseq_pkg::FIRST_END_HALF;
            adcseq_pkg::ADCSEQ_KIND_NORMAL: h = adcseq_pkg::NORMAL_END_HALF;
            adcseq_pkg::ADCSEQ_KIND_AUTO:   h = adcseq_pkg::AUTO_END_HALF;
            adcseq_pkg::ADCSEQ_KIND_FREE:   h = adcseq_pkg::FREE_END_HALF;
        endcase
        return h;
    endfunction : end_half

    function automatic logic [adcseq_pkg::HALF_W-1:0] sample_half(
        input adcseq_pkg::adcseq_kind_type kind);
        logic [adcseq_pkg::HALF_W-1:0] h;
        h = adcseq_pkg::NORMAL_SAMPLE_HALF;
        unique case (kind)
            adcseq_pkg::ADCSEQ_KIND_FIRST:  h = adcseq_pkg::FIRST_SAMPLE_HALF;
            adcseq_pkg::ADCSEQ_KIND_NORMAL: h = adcseq_pkg::NORMAL_SAMPLE_HALF;
            adcseq_pkg::ADCSEQ_KIND_AUTO:   h = adcseq_pkg::AUTO_SAMPLE_HALF;
            adcseq_pkg::ADCSEQ_KIND_FREE:   h = adcseq_pkg::FREE_SAMPLE_HALF;
        endcase
        return h;
    endfunction : sample_half

    logic                              converter_enable_reg;
    logic                              conversion_start_bit_reg;
    logic                              auto_trigger_enable_reg;
    logic                              free_run_reg;
    logic                              conversion_done_flag_reg;
    logic [adcseq_pkg::PS_W-1:0]       prescale_reg;
    adcseq_pkg::adcseq_select_type     input_select_register_reg;
    adcseq_pkg::adcseq_select_type     active_select_reg;
    logic [adcseq_pkg::RESULT_W-1:0]   result_reg;
    logic                              first_pending_reg;
    logic [adcseq_pkg::PCNT_W-1:0]     pcnt_reg;
    logic                              adc_clk_reg;
    adcseq_state_type                  state_reg;
    adcseq_pkg::adcseq_kind_type       kind_reg;
    logic [adcseq_pkg::HALF_W-1:0]     half_reg;
    logic                              sample_reg;
    logic                              done_pulse_reg;
    logic [2:0]                        trig_sync_reg;
    adcseq_pkg::adcseq_sleep_type      sleep_prev_reg;
    logic                              sleep_arm_reg;
    logic                              wr_phase_reg;
    logic [7:0]                        wr_addr_reg;
    logic [31:0]                       rdata_reg;

    logic                              half_tick;
    logic                              rise_tick;
    logic                              trig_edge;
    logic                              auto_start;
    logic                              sw_start;
    logic                              sleep_start;
    logic [adcseq_pkg::HALF_W-1:0]     half_next;
    logic                              finish;
    logic                              locked;
    logic                              addr_phase;
    logic                              ctrl_write;
    logic [31:0]                       wdata;

    assign addr_phase = i_ahb.hsel && i_ahb.hready && (i_ahb.htrans == adcseq_pkg::HTRANS_NONSEQ);
    assign ctrl_write = wr_phase_reg && (wr_addr_reg == adcseq_pkg::CTRL_OFFSET);
    assign wdata      = i_ahb.hwdata;

    // Two sync stages plus edge stage
    assign trig_edge  = trig_sync_reg[1] && !trig_sync_reg[2];
    assign auto_start = converter_enable_reg && auto_trigger_enable_reg && !free_run_reg
                        && trig_edge && (state_reg != ADCSEQ_CONVERT);
    assign sw_start   = ctrl_write && wdata[adcseq_pkg::CTRL_START_BIT]
                        && wdata[adcseq_pkg::CTRL_ENABLE_BIT];
    assign sleep_start = sleep_arm_reg && i_cpu_halted;

    assign half_tick = converter_enable_reg && (pcnt_reg == half_length(prescale_reg) - 7'h01);
    assign rise_tick = half_tick && !adc_clk_reg;
    assign half_next = half_reg + 6'h01;
    assign finish    = (state_reg == ADCSEQ_CONVERT) && half_tick
                       && (half_next == end_half(kind_reg));
    assign locked    = (state_reg == ADCSEQ_CONVERT)
                       && (half_reg + adcseq_pkg::LAST_CYCLE_HALVES < end_half(kind_reg));

    // Bus slave: address phase captured, write applied in data phase
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_phase_reg <= 1'b0;
            wr_addr_reg  <= 8'h00;
            rdata_reg    <= 32'h0000_0000;
        end else begin
            wr_phase_reg <= addr_phase && i_ahb.hwrite;
            wr_addr_reg  <= i_ahb.haddr[7:0];
            if (addr_phase && !i_ahb.hwrite) begin
                unique case (i_ahb.haddr[7:0])
                    adcseq_pkg::CTRL_OFFSET: rdata_reg <= {24'h000000, prescale_reg,
                        conversion_done_flag_reg, free_run_reg, auto_trigger_enable_reg,
                        conversion_start_bit_reg, converter_enable_reg};
                    adcseq_pkg::SELECT_OFFSET: rdata_reg <= {24'h000000, input_select_register_reg};
                    adcseq_pkg::ACTIVE_OFFSET: rdata_reg <= {23'h000000,
                        state_reg == ADCSEQ_CONVERT, active_select_reg};
                    adcseq_pkg::RESULT_OFFSET: rdata_reg <= {22'h000000, result_reg};
                    default: rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Software-owned control and selection buffer
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            converter_enable_reg      <= 1'b0;
            auto_trigger_enable_reg   <= 1'b0;
            free_run_reg              <= 1'b0;
            prescale_reg              <= adcseq_pkg::PS_RESET;
            input_select_register_reg <= '{ref_sel: adcseq_pkg::REF_RESET,
                                           chan_sel: adcseq_pkg::CHAN_RESET};
        end else begin
            if (ctrl_write) begin
                converter_enable_reg    <= wdata[adcseq_pkg::CTRL_ENABLE_BIT];
                auto_trigger_enable_reg <= wdata[adcseq_pkg::CTRL_AUTO_BIT];
                free_run_reg            <= wdata[adcseq_pkg::CTRL_FREE_BIT];
                prescale_reg <= wdata[adcseq_pkg::CTRL_PS_MSB:adcseq_pkg::CTRL_PS_LSB];
            end
            if (wr_phase_reg && (wr_addr_reg == adcseq_pkg::SELECT_OFFSET)) begin
                input_select_register_reg <= wdata[adcseq_pkg::SEL_REF_MSB:adcseq_pkg::SEL_CHAN_LSB];
            end
        end
    end

    // Prescaler and converter clock
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pcnt_reg    <= 7'h00;
            adc_clk_reg <= 1'b0;
        end else if (!converter_enable_reg || auto_start) begin
            pcnt_reg    <= 7'h00;
            adc_clk_reg <= 1'b0;
        end else if (half_tick) begin
            pcnt_reg    <= 7'h00;
            adc_clk_reg <= !adc_clk_reg;
        end else begin
            pcnt_reg    <= pcnt_reg + 7'h01;
        end
    end

    // Trigger synchroniser
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            trig_sync_reg <= 3'h0;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], i_trigger};
        end
    end

    // Sleep entry starts a conversion once the core halts
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sleep_prev_reg <= adcseq_pkg::ADCSEQ_SLEEP_ACTIVE;
            sleep_arm_reg  <= 1'b0;
        end else begin
            sleep_prev_reg <= i_sleep_mode;
            if (i_sleep_mode != sleep_prev_reg && converter_enable_reg
                && state_reg == ADCSEQ_IDLE
                && (i_sleep_mode == adcseq_pkg::ADCSEQ_SLEEP_IDLE
                    || i_sleep_mode == adcseq_pkg::ADCSEQ_SLEEP_NOISE)) begin
                sleep_arm_reg <= 1'b1;
            end else if (sleep_start || !converter_enable_reg) begin
                sleep_arm_reg <= 1'b0;
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg         <= ADCSEQ_IDLE;
            kind_reg          <= adcseq_pkg::ADCSEQ_KIND_FIRST;
            half_reg          <= 6'h00;
            first_pending_reg <= 1'b1;
            sample_reg        <= 1'b0;
        end else begin
            sample_reg <= 1'b0;
            if (!converter_enable_reg) begin
                state_reg         <= ADCSEQ_IDLE;
                first_pending_reg <= 1'b1;
            end else begin
                unique case (state_reg)
                    ADCSEQ_IDLE: begin
                        if (auto_start) begin
                            state_reg <= ADCSEQ_CONVERT;
                            half_reg  <= 6'h00;
                            kind_reg  <= first_pending_reg ? adcseq_pkg::ADCSEQ_KIND_FIRST
                                                           : adcseq_pkg::ADCSEQ_KIND_AUTO;
                            first_pending_reg <= 1'b0;
                        end else if (sw_start || sleep_start) begin
                            state_reg <= ADCSEQ_WAIT_EDGE;
                        end
                    end
                    ADCSEQ_WAIT_EDGE: begin
                        if (auto_start) begin
                            state_reg <= ADCSEQ_CONVERT;
                            half_reg  <= 6'h00;
                            kind_reg  <= first_pending_reg ? adcseq_pkg::ADCSEQ_KIND_FIRST
                                                           : adcseq_pkg::ADCSEQ_KIND_AUTO;
                            first_pending_reg <= 1'b0;
                        end else if (rise_tick) begin
                            state_reg <= ADCSEQ_CONVERT;
                            half_reg  <= 6'h00;
                            kind_reg  <= first_pending_reg ? adcseq_pkg::ADCSEQ_KIND_FIRST
                                                           : adcseq_pkg::ADCSEQ_KIND_NORMAL;
                            first_pending_reg <= 1'b0;
                        end
                    end
                    ADCSEQ_CONVERT: begin
                        if (half_tick) begin
                            half_reg <= half_next;
                            sample_reg <= (half_next == sample_half(kind_reg));
                        end
                        if (finish) begin
                            if (auto_trigger_enable_reg && free_run_reg) begin
                                half_reg <= 6'h00;
                                kind_reg <= adcseq_pkg::ADCSEQ_KIND_FREE;
                            end else begin
                                state_reg <= ADCSEQ_IDLE;
                            end
                        end
                    end
                    default: state_reg <= ADCSEQ_IDLE;
                endcase
            end
        end
    end

    // Active selection copy
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            active_select_reg <= '{ref_sel: adcseq_pkg::REF_RESET,
                                   chan_sel: adcseq_pkg::CHAN_RESET};
        end else if (converter_enable_reg && !locked && !(finish && free_run_reg
                     && auto_trigger_enable_reg)) begin
            active_select_reg <= input_select_register_reg;
        end
    end

    // Completion: result, flag and start bit
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            conversion_start_bit_reg <= 1'b0;
            conversion_done_flag_reg <= 1'b0;
            result_reg               <= adcseq_pkg::RESULT_RESET;
            done_pulse_reg           <= 1'b0;
        end else begin
            done_pulse_reg <= finish;
            if (finish) begin
                result_reg <= i_sar_result;
            end
            if (finish) begin
                conversion_done_flag_reg <= 1'b1;
            end else if (ctrl_write && wdata[adcseq_pkg::CTRL_DONE_BIT]) begin
                conversion_done_flag_reg <= 1'b0;
            end
            if (!converter_enable_reg) begin
                conversion_start_bit_reg <= 1'b0;
            end else if (sw_start || sleep_start || auto_start) begin
                conversion_start_bit_reg <= 1'b1;
            end else if (finish && !(auto_trigger_enable_reg && free_run_reg)) begin
                conversion_start_bit_reg <= 1'b0;
            end
        end
    end

    assign o_ahb = '{hreadyout: 1'b1, hresp: adcseq_pkg::HRESP_OKAY, hrdata: rdata_reg};
    assign o_active_select        = active_select_reg;
    assign o_converter_clock      = adc_clk_reg;
    assign o_sample_hold          = sample_reg;
    assign o_converting           = conversion_start_bit_reg;
    assign o_conversion_done      = done_pulse_reg;
    assign o_conversion_done_flag = conversion_done_flag_reg;

endmodule : adcseq_sequencer

//--- test/adcseq_analog_model.sv
`timescale 1ns/10ps
module adcseq_analog_model (
    // Clock and reset
    input  wire logic                          i_mclk,
    input  wire logic                          i_rst,
    // Digital side
    input  wire logic                          i_sample_hold,
    input  wire adcseq_pkg::adcseq_select_type i_select,
    output logic [adcseq_pkg::RESULT_W-1:0]    o_result
);
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_result <= 10'h155;
        end else if (i_sample_hold) begin
            o_result <= {2'b10, i_select};
        end
    end
endmodule : adcseq_analog_model

//--- test/adcseq_checker.sv
`timescale 1ns/10ps
module adcseq_checker (
    // Clock and reset
    input wire logic                          i_mclk,
    input wire logic                          i_rst,
    // Watched outputs
    input wire adcseq_pkg::adcseq_select_type o_active_select,
    input wire logic                          o_converter_clock,
    input wire logic                          o_sample_hold,
    input wire logic                          o_converting,
    input wire logic                          o_conversion_done,
    input wire logic                          o_conversion_done_flag
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence s_no_done;
        !o_conversion_done [*8];
    endsequence
    sequence s_no_sample;
        !o_sample_hold [*8];
    endsequence
    AST_SAMPLE_IN_CONV:
        assert property (o_sample_hold |-> o_converting) else $error("sample outside conversion");
    AST_SEL_LOCKED:
        assert property (o_sample_hold |-> $stable(o_active_select)) else $error("select moved");
    AST_SAMPLE_SPACING:
        assert property (o_sample_hold |=> s_no_sample) else $error("second sample too soon");
    AST_SAMPLE_TO_DONE:
        assert property (o_sample_hold |=> s_no_done) else $error("done too soon");
    AST_DONE_PULSE:
        assert property (o_conversion_done |=> !o_conversion_done) else $error("done too long");
    AST_DONE_FLAG:
        assert property (o_conversion_done |-> o_conversion_done_flag) else $error("no flag");
    AST_FLAG_CAUSE:
        assert property ($rose(o_conversion_done_flag) |-> $past(o_converting))
            else $error("flag without conversion");
    AST_CLOCK_RUNS:
        assert property (o_converting && !o_converter_clock |->
            ##[1:260] (o_converter_clock || !o_converting)) else $error("converter clock stuck");
endmodule : adcseq_checker
bind adcseq_sequencer adcseq_checker u_chk (.i_mclk, .i_rst, .o_active_select,
    .o_converter_clock, .o_sample_hold, .o_converting, .o_conversion_done,
    .o_conversion_done_flag);

//--- test/adc_conversion_sequencer_tb.sv
`timescale 1ns/10ps
module adc_conversion_sequencer_tb;
    logic                           i_mclk = 1'b0;
    logic                           i_rst = 1'b1;
    adcseq_pkg::adcseq_ahb_req_type i_ahb = '0;
    adcseq_pkg::adcseq_ahb_rsp_type o_ahb;
    adcseq_pkg::adcseq_sleep_type   i_sleep_mode = adcseq_pkg::ADCSEQ_SLEEP_ACTIVE;
    logic                           i_cpu_halted = 1'b0;
    logic                           i_trigger = 1'b0;
    logic [9:0]                     sar;
    adcseq_pkg::adcseq_select_type  act;
    logic                           ck, sh, conv, done, flag;
    logic [31:0]                    got, r, e;
    logic [31:0]                    q[$];
    logic [7:0]                     sa, sb;
    int                             fail_count = 0, checks_done = 0, dones = 0, c1, c2;
    event                           ev;
    always #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (done === 1'b1) dones++;
    adcseq_sequencer u_dut (.i_mclk, .i_rst, .i_ahb, .o_ahb, .i_sleep_mode, .i_cpu_halted,
        .i_trigger, .i_sar_result(sar), .o_active_select(act), .o_converter_clock(ck),
        .o_sample_hold(sh), .o_converting(conv), .o_conversion_done(done),
        .o_conversion_done_flag(flag));
    adcseq_analog_model u_ana (.i_mclk, .i_rst, .i_sample_hold(sh), .i_select(act),
        .o_result(sar));
    function automatic logic [31:0] code(input logic [7:0] s);
        code = {22'h0, 2'b10, s};
    endfunction : code
    task automatic chk(input logic [31:0] ex, input logic [31:0] gv);
        q.push_back(ex);
        got = gv;
        ->ev;
        // Let the compare process run before the next note
        @(posedge i_mclk);
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        i_ahb.hsel <= 1'b1;
        i_ahb.haddr <= {24'h0, a};
        i_ahb.htrans <= adcseq_pkg::HTRANS_NONSEQ;
        i_ahb.hwrite <= w;
        i_ahb.hsize <= 3'h2;
        do @(posedge i_mclk); while (o_ahb.hreadyout !== 1'b1);
        i_ahb.htrans <= 2'h0;
        i_ahb.hsel <= 1'b0;
        i_ahb.hwdata <= d;
        do @(posedge i_mclk); while (o_ahb.hreadyout !== 1'b1);
        r = o_ahb.hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        bus(a, 1'b0, 32'h0);
        chk(ex, r);
    endtask : rd
    task automatic wdone(output int c);
        c = 0;
        while (done !== 1'b1 && c < 300) begin
            @(posedge i_mclk);
            c++;
        end
        if (c >= 300) fail_count++;
    endtask : wdone
    task automatic trig(output int c);
        int d0;
        d0 = dones;
        repeat ($urandom % 5) @(posedge i_mclk);
        i_trigger <= 1'b1;
        c = 0;
        while (sh !== 1'b1 && c < 100) begin
            @(posedge i_mclk);
            c++;
        end
        i_trigger <= 1'b0;
        repeat (3) @(posedge i_mclk);
        i_trigger <= 1'b1;
        wdone(c2);
        repeat (4) @(posedge i_mclk);
        chk(d0 + 1, dones);
        i_trigger <= 1'b0;
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h55);
    endtask : trig
    task automatic results;
        $display("checks %0d fails %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results
    initial forever begin
        @ev;
        e = q.pop_front();
        checks_done++;
        if (got !== e) begin
            $display("BAD t=%0t exp=%h got=%h", $time, e, got);
            fail_count++;
        end
    end
    initial begin
        repeat (6000) @(posedge i_mclk);
        fail_count++;
        results();
    end
    initial begin
        void'($urandom(32'hf961));
        sa = $urandom;
        sb = ~sa;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        i_ahb.hready <= 1'b1;
        @(posedge i_mclk);
        rd(adcseq_pkg::CTRL_OFFSET, 32'h0);
        rd(adcseq_pkg::SELECT_OFFSET, 32'h0);
        rd(8'h10, 32'h0);
        bus(adcseq_pkg::SELECT_OFFSET, 1'b1, {24'h0, sa});
        rd(adcseq_pkg::SELECT_OFFSET, {24'h0, sa});
        $display("test 1 end");
        // Enable first: the start bit is only taken while enabled
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h1);
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h3);
        wdone(c1);
        chk(1, c1 >= 50 && c1 <= 53);
        rd(adcseq_pkg::CTRL_OFFSET, 32'h11);
        rd(adcseq_pkg::RESULT_OFFSET, code(sa));
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h13);
        @(posedge i_mclk);
        bus(adcseq_pkg::SELECT_OFFSET, 1'b1, {24'h0, sb});
        wdone(c1);
        chk(1, c1 >= 23 && c1 <= 26);
        rd(adcseq_pkg::RESULT_OFFSET, code(sa));
        rd(adcseq_pkg::ACTIVE_OFFSET, {24'h0, sb});
        $display("test 2 end");
        // Divide by four so a prescaler restart shows in the delay
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h55);
        trig(c1);
        trig(c2);
        chk(c1, c2);
        chk(1, c1 >= 8 && c1 <= 14);
        $display("test 3 end");
        bus(adcseq_pkg::SELECT_OFFSET, 1'b1, {24'h0, sa});
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h1f);
        wdone(c1);
        bus(adcseq_pkg::SELECT_OFFSET, 1'b1, {24'h0, sb});
        rd(adcseq_pkg::CTRL_OFFSET, 32'h1f);
        wdone(c1);
        rd(adcseq_pkg::RESULT_OFFSET, code(sa));
        wdone(c1);
        rd(adcseq_pkg::RESULT_OFFSET, code(sb));
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h11);
        // Chained conversion still runs out before single mode holds
        wdone(c1);
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h11);
        $display("test 4 end");
        c2 = dones;
        i_sleep_mode <= adcseq_pkg::ADCSEQ_SLEEP_OTHER;
        i_cpu_halted <= 1'b1;
        repeat (80) @(posedge i_mclk);
        chk(c2, dones);
        rd(adcseq_pkg::CTRL_OFFSET, 32'h1);
        i_sleep_mode <= adcseq_pkg::ADCSEQ_SLEEP_NOISE;
        repeat (10) @(posedge i_mclk);
        i_sleep_mode <= adcseq_pkg::ADCSEQ_SLEEP_ACTIVE;
        i_cpu_halted <= 1'b0;
        wdone(c1);
        chk(1, c1 < 300);
        rd(adcseq_pkg::CTRL_OFFSET, 32'h11);
        bus(adcseq_pkg::CTRL_OFFSET, 1'b1, 32'h0);
        repeat (10) @(posedge i_mclk);
        chk(0, ck);
        $display("test 5 end");
        results();
    end
endmodule : adc_conversion_sequencer_tb
